// ### verilog/rtzio_pkg.sv
// package: constants and types for the readout table and zero i/o block
package rtzio_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int POS_W = 24;
    localparam int IDX_W = 7;
    localparam int TBL_N = 99;
    localparam logic [IDX_W-1:0] IDX_MAX = 7'h63;
    localparam logic [IDX_W-1:0] IDX_NONE = 7'h00;
    localparam logic [POS_W-1:0] POS_ZERO = 24'h000000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int HOLD_MS = 100;
    localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int CNT_W = 26;
    localparam logic [3:0] DUR_DEFAULT = 4'h1;
    // ------------------------------------------------------------
    // axis and duration selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RTZIO_AX_X, RTZIO_AX_Y, RTZIO_AX_Z}
        rtzio_axis_t;
    // index 0 = 30 ms, 1 = 100 ms, 2..9 = 200..900 ms, 10 = 1 s
    function automatic logic [10:0] rtzio_dur_ms(input logic [3:0] sel);
        logic [10:0] r;
        r = 11'h064;
        if (sel == 4'h0) begin
            r = 11'h01e;
        end else if (sel >= 4'ha) begin
            r = 11'h3e8;
        end else begin
            r = 11'(sel) * 11'h064;
        end
        return r;
    endfunction : rtzio_dur_ms
endpackage : rtzio_pkg

// ### verilog/rtzio_top.sv
// readout datum/tool tables, axis coupling and zero outputs
`timescale 1ns/1ns
// Behaviour
// - datum table of 99; clear erases all
// - datum 0 selects machine home
// - tool table stores X and Z offsets
// - tool recall 1..99; tool 0 no offset
// - shift-tool-Z sets all Z offsets
// - shift-tool-Z only with active tool
// - clear-tool erases all 99 tools
// - coupling shows sum; command toggles
// - coupling only on three-axis units
// - zero output while enabled axis equals zero
// - near-zero output within range on axis
// - only one near-zero axis selected
// - zero-output enable toggles per axis, off
// - zero crossing holds output for duration
// - duration 30 ms, 100..900 ms, 1 s
module rtzio_top
    import rtzio_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int MS_CYCLES = MS_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic THREE_AXIS,
    input wire logic [POS_W-1:0] POS_X,
    input wire logic [POS_W-1:0] POS_Y,
    input wire logic [POS_W-1:0] POS_Z,
    input wire logic [POS_W-1:0] POS_W2,
    input wire logic DATUM_WR,
    input wire logic DATUM_RECALL,
    input wire logic DATUM_CLEAR,
    input wire logic [IDX_W-1:0] DATUM_IDX,
    input wire logic [POS_W-1:0] DATUM_X_IN,
    input wire logic [POS_W-1:0] DATUM_Y_IN,
    input wire logic TOOL_WR,
    input wire logic TOOL_RECALL,
    input wire logic TOOL_CLEAR,
    input wire logic TOOL_SHIFT_Z,
    input wire logic [IDX_W-1:0] TOOL_IDX,
    input wire logic [POS_W-1:0] TOOL_X_IN,
    input wire logic [POS_W-1:0] TOOL_Z_IN,
    input wire logic COUPLE_TOGGLE,
    input wire logic [2:0] ZERO_EN_TOGGLE,
    input wire logic NZ_SELECT,
    input wire logic [1:0] NZ_AXIS,
    input wire logic [POS_W-1:0] NZ_RANGE,
    input wire logic DUR_WR,
    input wire logic [3:0] DUR_SEL,
    input wire logic [5:0] REMOTE_IN,
    output logic [POS_W-1:0] DISP_X,
    output logic [POS_W-1:0] DISP_Y,
    output logic [POS_W-1:0] DISP_Z,
    output logic [IDX_W-1:0] ACTIVE_TOOL,
    output logic COUPLED,
    output logic [2:0] ZERO_EN,
    output logic [2:0] AXIS_ZERO_OUT,
    output logic [1:0] NZ_AXIS_SEL,
    output logic NEAR_ZERO_OUTPUT,
    output logic ZERO_PULSE_OUT,
    output logic [5:0] REMOTE_FIRE
);
    // ------------------------------------------------------------
    // tables
    // ------------------------------------------------------------
    logic [POS_W-1:0] datum_x_r [1:TBL_N];
    logic [POS_W-1:0] datum_y_r [1:TBL_N];
    logic [POS_W-1:0] tool_x_r [1:TBL_N];
    logic [POS_W-1:0] tool_z_r [1:TBL_N];
    logic [IDX_W-1:0] datum_sel_r;
    logic [IDX_W-1:0] tool_sel_r;
    logic [POS_W-1:0] off_dx, off_dy, off_tx, off_tz;
    logic [POS_W-1:0] z_sum;
    logic [CNT_W-1:0] dur_cyc;
    logic [3:0] dur_sel_r;
    logic [2:0] zero_now;
    logic [POS_W-1:0] nz_pos;
    logic nz_was_zero_r;
    logic [CNT_W-1:0] pulse_cnt_r;
    logic [POS_W-1:0] nz_mag;

    // table writes; clear is one-cycle, costing no per-entry walk
    always_ff @(posedge CORE_CLK) begin
        for (int i = 1; i <= TBL_N; i++) begin
            if (RST || DATUM_CLEAR) begin
                datum_x_r[i] <= POS_ZERO;
                datum_y_r[i] <= POS_ZERO;
            end else if (DATUM_WR && DATUM_IDX == IDX_W'(i)) begin
                datum_x_r[i] <= DATUM_X_IN;
                datum_y_r[i] <= DATUM_Y_IN;
            end
            if (RST || TOOL_CLEAR) begin
                tool_x_r[i] <= POS_ZERO;
                tool_z_r[i] <= POS_ZERO;
            end else if (TOOL_SHIFT_Z && tool_sel_r != IDX_NONE) begin
                tool_z_r[i] <= TOOL_Z_IN;
            end else if (TOOL_WR && TOOL_IDX == IDX_W'(i)) begin
                tool_x_r[i] <= TOOL_X_IN;
                tool_z_r[i] <= TOOL_Z_IN;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            datum_sel_r <= IDX_NONE;
        end else if (DATUM_RECALL && DATUM_IDX <= IDX_MAX) begin
            datum_sel_r <= DATUM_IDX;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            tool_sel_r <= IDX_NONE;
        end else if (TOOL_RECALL && TOOL_IDX <= IDX_MAX) begin
            tool_sel_r <= TOOL_IDX;
        end
    end

    always_comb begin
        off_dx = POS_ZERO;
        off_dy = POS_ZERO;
        off_tx = POS_ZERO;
        off_tz = POS_ZERO;
        if (datum_sel_r != IDX_NONE) begin
            off_dx = datum_x_r[datum_sel_r];
            off_dy = datum_y_r[datum_sel_r];
        end
        if (tool_sel_r != IDX_NONE) begin
            off_tx = tool_x_r[tool_sel_r];
            off_tz = tool_z_r[tool_sel_r];
        end
    end

    // ------------------------------------------------------------
    // coupling and displays
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            COUPLED <= 1'b0;
        end else if (!THREE_AXIS) begin
            COUPLED <= 1'b0;
        end else if (COUPLE_TOGGLE) begin
            COUPLED <= !COUPLED;
        end
    end
    assign z_sum = COUPLED ? POS_Z + POS_W2 : POS_Z;
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            DISP_X <= POS_ZERO;
            DISP_Y <= POS_ZERO;
            DISP_Z <= POS_ZERO;
        end else begin
            DISP_X <= POS_X - off_dx - off_tx;
            DISP_Y <= POS_Y - off_dy;
            DISP_Z <= z_sum - off_tz;
        end
    end
    assign ACTIVE_TOOL = tool_sel_r;
    // ------------------------------------------------------------
    // zero outputs
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ZERO_EN <= 3'h0;
        end else begin
            ZERO_EN <= ZERO_EN ^ ZERO_EN_TOGGLE;
        end
    end

    assign zero_now = {DISP_Z == POS_ZERO, DISP_Y == POS_ZERO,
        DISP_X == POS_ZERO};

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            AXIS_ZERO_OUT <= 3'h0;
        end else begin
            AXIS_ZERO_OUT <= zero_now & ZERO_EN;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            NZ_AXIS_SEL <= 2'h0;
        end else if (NZ_SELECT && NZ_AXIS <= 2'h2) begin
            NZ_AXIS_SEL <= NZ_AXIS;
        end
    end

    always_comb begin
        unique case (NZ_AXIS_SEL)
            2'h1: nz_pos = DISP_Y;
            2'h2: nz_pos = DISP_Z;
            default: nz_pos = DISP_X;
        endcase
    end

    // signed magnitude so the range is symmetric about zero
    assign nz_mag = nz_pos[POS_W-1] ? POS_ZERO - nz_pos : nz_pos;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            NEAR_ZERO_OUTPUT <= 1'b0;
        end else begin
            NEAR_ZERO_OUTPUT <= nz_mag <= NZ_RANGE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            dur_sel_r <= DUR_DEFAULT;
        end else if (DUR_WR && DUR_SEL <= 4'ha) begin
            dur_sel_r <= DUR_SEL;
        end
    end
    assign dur_cyc = CNT_W'(rtzio_dur_ms(dur_sel_r) * MS_CYCLES);
    // crossing = selected axis reaches zero from nonzero
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            nz_was_zero_r <= 1'b1;
            pulse_cnt_r <= '0;
        end else begin
            nz_was_zero_r <= nz_pos == POS_ZERO;
            if (nz_pos == POS_ZERO && !nz_was_zero_r
                    && ZERO_EN[NZ_AXIS_SEL]) begin
                pulse_cnt_r <= dur_cyc;
            end else if (pulse_cnt_r != '0) begin
                pulse_cnt_r <= pulse_cnt_r - 1'b1;
            end
        end
    end
    assign ZERO_PULSE_OUT = pulse_cnt_r != '0;
    // ------------------------------------------------------------
    // remote inputs: x0 z0 recall store y0 print
    // ------------------------------------------------------------
    for (genvar g = 0; g < 6; g++) begin : g_in
        logic [CNT_W-1:0] hold_r;
        always_ff @(posedge CORE_CLK) begin
            if (RST || !REMOTE_IN[g]) begin
                hold_r <= '0;
                REMOTE_FIRE[g] <= 1'b0;
            end else begin
                // counter saturates one past the threshold: no refire
                if (hold_r != CNT_W'(HOLD_CYCLES)) begin
                    hold_r <= hold_r + 1'b1;
                end
                REMOTE_FIRE[g] <= hold_r == CNT_W'(HOLD_CYCLES - 1);
            end
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb_core @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    property p_coup_off;
        !THREE_AXIS |=> !COUPLED;
    endproperty
    a_coup_off: assert property (p_coup_off) else $error("coupling on");
    property p_zero_out;
        AXIS_ZERO_OUT[0] |-> $past(ZERO_EN[0]);
    endproperty
    a_zero_out: assert property (p_zero_out) else $error("zero out");
    property p_fire_once;
        REMOTE_FIRE[0] |=> !REMOTE_FIRE[0];
    endproperty
    a_fire_once: assert property (p_fire_once) else $error("refire");
    property p_fire_held;
        REMOTE_FIRE[0] |-> $past(REMOTE_IN[0], 2);
    endproperty
    a_fire_held: assert property (p_fire_held) else $error("short");
    property p_tool_sel;
        TOOL_RECALL && TOOL_IDX <= IDX_MAX |=> ACTIVE_TOOL == $past(TOOL_IDX);
    endproperty
    a_tool_sel: assert property (p_tool_sel) else $error("tool");
    property p_en_tog;
        ZERO_EN_TOGGLE != 3'h0 |=>
            (ZERO_EN ^ $past(ZERO_EN)) == $past(ZERO_EN_TOGGLE);
    endproperty
    a_en_tog: assert property (p_en_tog) else $error("enable");
    property p_pulse;
        $rose(ZERO_PULSE_OUT) |-> $past(ZERO_EN[NZ_AXIS_SEL]);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_nz_sel;
        NZ_SELECT && NZ_AXIS != 2'h3 |=> NZ_AXIS_SEL == $past(NZ_AXIS);
    endproperty
    a_nz_sel: assert property (p_nz_sel) else $error("nz sel");
    c_couple: cover property (@(posedge CORE_CLK) $rose(COUPLED));
    c_pulse: cover property (@(posedge CORE_CLK) $fell(ZERO_PULSE_OUT));
    c_fire: cover property (@(posedge CORE_CLK) REMOTE_FIRE[2]);
endmodule : rtzio_top

// ### verification/rtzio_remote_model.sv
// model of the machine-side switches that drive the remote inputs
`timescale 1ns/1ns
module rtzio_remote_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [2:0] ch,
    input wire logic [31:0] len,
    output logic [5:0] remote_in
);
    // ------------------------------------------------------------
    // held contact
    // ------------------------------------------------------------
    int left_r;
    initial begin
        remote_in = 6'h00;
        left_r = 0;
    end
    // an open opto input reads inactive, so release drives low
    always @(posedge clk) begin
        if (go) begin
            remote_in <= 6'h01 << ch;
            left_r <= len;
        end else if (left_r > 1) begin
            left_r <= left_r - 1;
        end else begin
            left_r <= 0;
            remote_in <= 6'h00;
        end
    end
endmodule : rtzio_remote_model

// ### verification/rtzio_tb_top.sv
// self-checking bench for the readout tables and zero outputs
`timescale 1ns/1ns
module rtzio_tb_top;
    import rtzio_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    // short counts keep the run small; expectations scale with them
    localparam int HOLD_T = 20;
    localparam int MS_T = 3;
    localparam int DW = 0, DR = 1, DC = 2, TW = 3, TR = 4, TC = 5;
    localparam int SZ = 6, CP = 7, NZ = 8, DU = 9, ZX = 10, ZY = 11, ZZ = 12;
    logic core_clk, rst, three_axis, rm_go;
    logic [12:0] cmd;
    logic [IDX_W-1:0] idx, act;
    logic [POS_W-1:0] px, py, pz, pw, va, vb, dx, dy, dz;
    logic [2:0] zen, azo, rm_ch;
    logic [1:0] nsel;
    logic cpl, nzo, zpo;
    logic [5:0] rin, rfire;
    int rm_len, err_count, checks, cyc, n, early;
    rtzio_top #(.HOLD_CYCLES(HOLD_T), .MS_CYCLES(MS_T)) i_dut (
        .CORE_CLK(core_clk), .RST(rst), .THREE_AXIS(three_axis),
        .POS_X(px), .POS_Y(py), .POS_Z(pz), .POS_W2(pw),
        .DATUM_WR(cmd[DW]), .DATUM_RECALL(cmd[DR]), .DATUM_CLEAR(cmd[DC]),
        .DATUM_IDX(idx), .DATUM_X_IN(va), .DATUM_Y_IN(vb),
        .TOOL_WR(cmd[TW]), .TOOL_RECALL(cmd[TR]), .TOOL_CLEAR(cmd[TC]),
        .TOOL_SHIFT_Z(cmd[SZ]), .TOOL_IDX(idx), .TOOL_X_IN(va),
        .TOOL_Z_IN(vb), .COUPLE_TOGGLE(cmd[CP]),
        .ZERO_EN_TOGGLE(cmd[12:10]), .NZ_SELECT(cmd[NZ]),
        .NZ_AXIS(idx[1:0]), .NZ_RANGE(24'h000005), .DUR_WR(cmd[DU]),
        .DUR_SEL(idx[3:0]), .REMOTE_IN(rin), .DISP_X(dx), .DISP_Y(dy),
        .DISP_Z(dz), .ACTIVE_TOOL(act), .COUPLED(cpl), .ZERO_EN(zen),
        .AXIS_ZERO_OUT(azo), .NZ_AXIS_SEL(nsel), .NEAR_ZERO_OUTPUT(nzo),
        .ZERO_PULSE_OUT(zpo), .REMOTE_FIRE(rfire)
    );
    rtzio_remote_model i_rem (
        .clk(core_clk), .go(rm_go), .ch(rm_ch), .len(rm_len),
        .remote_in(rin)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task final_report;
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task go(input int b, i, a, c);
        @(posedge core_clk);
        cmd[b] <= 1'b1;
        idx <= 7'(i);
        va <= 24'(a);
        vb <= 24'(c);
        @(posedge core_clk);
        cmd <= 13'h0000;
        tick(3);
    endtask : go
    task setp(input logic [23:0] x, y);
        @(posedge core_clk);
        px <= x;
        py <= y;
        tick(4);
    endtask : setp
    // counts cycles of the zero pulse after x arrives at zero
    task zcross(input int win);
        setp(24'h000064, 24'h000009);
        @(posedge core_clk);
        px <= 24'h000000;
        n = 0;
        repeat (win) begin
            tick(1);
            if (zpo === 1'b1) n++;
        end
    endtask : zcross
    task rem(input int ch, input int len, input int exp);
        @(posedge core_clk);
        rm_ch <= ch[2:0];
        rm_len <= len;
        rm_go <= 1'b1;
        @(posedge core_clk);
        rm_go <= 1'b0;
        n = 0;
        early = 0;
        for (int k = 0; k < len + HOLD_T + 6; k++) begin
            tick(1);
            if (rfire[ch] === 1'b1) n++;
            if (rfire !== 6'h00 && k < HOLD_T - 3) early++;
        end
        check(24'(n), 24'(exp));
        check(24'(early), 24'h000000);
    endtask : rem
    // ------------------------------------------------------------
    // clock, timeout, sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        {rst, three_axis, rm_go, cmd, idx, rm_ch, rm_len} = '0;
        {px, py, pz, pw, va, vb} = '0;
        {err_count, checks, cyc} = '0;
        rst = 1'b1;
        pz = 24'h00003c;
        pw = 24'h000008;
        tick(3);
        check({act, cpl, zen, azo, nsel, nzo, zpo, rfire}, 24'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        setp(24'h000064, 24'h000032);
        go(TW, 5, 24'h00000a, 24'h000014);
        go(TR, 5, 0, 0);
        check(24'(act), 24'h5);
        check(dx, 24'h00005a);
        check(dz, 24'h000028);
        go(TW, 99, 24'h000003, 24'h000004);
        go(TR, 99, 0, 0);
        check(dx, 24'h000061);
        go(TR, 100, 0, 0);
        check(24'(act), 24'h63);
        go(SZ, 0, 0, 24'h000007);
        check(dz, 24'h000035);
        go(TR, 5, 0, 0);
        check(dz, 24'h000035);
        go(TR, 0, 0, 0);
        check(dx, 24'h000064);
        go(SZ, 0, 0, 24'h000001);
        go(TR, 5, 0, 0);
        check(dz, 24'h000035);
        go(TC, 0, 0, 0);
        check(dx, 24'h000064);
        check(dz, 24'h00003c);
        go(DW, 3, 24'h000028, 24'h000005);
        go(DW, 99, 24'h000001, 24'h000001);
        go(DR, 3, 0, 0);
        check(dx, 24'h00003c);
        check(dy, 24'h00002d);
        go(DR, 0, 0, 0);
        check(dx, 24'h000064);
        go(DC, 0, 0, 0);
        go(DR, 99, 0, 0);
        check(dx, 24'h000064);
        go(CP, 0, 0, 0);
        check(24'(cpl), 24'h0);
        @(posedge core_clk);
        three_axis <= 1'b1;
        go(CP, 0, 0, 0);
        check(dz, 24'h000044);
        go(CP, 0, 0, 0);
        check(24'(cpl), 24'h0);
        go(NZ, 1, 0, 0);
        go(NZ, 3, 0, 0);
        check(24'(nsel), 24'h1);
        setp(24'h000064, 24'hfffffd);
        check(24'(nzo), 24'h1);
        setp(24'h000064, 24'h000009);
        check(24'(nzo), 24'h0);
        go(ZX, 0, 0, 0);
        go(NZ, 0, 0, 0);
        check(24'(nsel), 24'h0);
        setp(24'h000000, 24'h000000);
        check(24'(azo), 24'h1);
        // default pulse; three of its cycles passed inside setp
        n = 0;
        repeat (300) begin
            tick(1);
            if (zpo === 1'b1) n++;
        end
        check(24'(n), 24'(100 * MS_T - 3));
        for (int i = 0; i < 12; i++) begin
            go(DU, (i == 11) ? 7'h0f : 7'(i), 0, 0);
            zcross(3100);
            check(24'(n), 24'((i == 0) ? 30 * MS_T : (i >= 10)
                ? 1000 * MS_T : i * 100 * MS_T));
        end
        go(ZX, 0, 0, 0);
        check(24'(zen), 24'h0);
        go(ZY, 0, 0, 0);
        go(ZZ, 0, 0, 0);
        check(24'(zen), 24'h6);
        zcross(200);
        check(24'(n), 24'h0);
        for (int c = 0; c < 6; c++) rem(c, 30, 1);
        rem(2, 10, 0);
        final_report();
    end
endmodule : rtzio_tb_top
